// ### rtl/oscsel_top.sv
/*
  Oscillator clock select: control and trim registers over APB, the clock
  switch sequencer, lock and fail flags, postscaler and mode decode of the
  primary oscillator. Assumes analog oscillators and the PLL report ready
  and lock levels synchronous to clk_in, and a fail monitor pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module oscsel_top
  import oscsel_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [11:0]               paddr_in,
  input  wire logic [31:0]               pwdata_in,
  input  wire logic [3:0]                pstrb_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  input  wire logic [2:0]                startup_source_cfg_in,
  input  wire oscsel_pkg::oscsel_pmode_t primary_mode_cfg_in,
  input  wire logic [4:0]                src_ready_in,
  input  wire logic                      pll_locked_in,
  input  wire logic                      clock_fail_in,
  output logic      [2:0]                current_source_sel_out,
  output logic                           secondary_osc_enable_out,
  output logic      [3:0]                rc_trim_field_out,
  output logic                           sysclk_tick_out,
  output logic      [1:0]                pll_prediv_out,
  output logic      [4:0]                pll_mult_out,
  output logic      [1:0]                pll_input_sel_out,
  output logic                           primary_osc_out_out,
  output logic                           primary_osc_out_oe_out
);
  import oscsel_pkg::*;

  logic [2:0]    current_source_sel;
  logic [2:0]    new_source_sel;
  logic [1:0]    sysclk_divider;
  logic          lock_flag;
  logic          clock_fail_flag;
  logic          secondary_osc_enable;
  logic          switch_request;
  logic [3:0]    rc_trim_field;
  logic [1:0]    key_lo;
  logic [1:0]    key_hi;
  oscsel_state_t state;
  logic          cfg_loaded;

  logic [2:0]    next_current_source_sel;
  logic [2:0]    next_new_source_sel;
  logic [1:0]    next_sysclk_divider;
  logic          next_lock_flag;
  logic          next_clock_fail_flag;
  logic          next_secondary_osc_enable;
  logic          next_switch_request;
  logic [3:0]    next_rc_trim_field;
  logic [1:0]    next_key_lo;
  logic [1:0]    next_key_hi;
  oscsel_state_t next_state;
  logic [31:0]   next_prdata;

  logic        wr_access;
  logic        rd_access;
  logic        hit_ctrl;
  logic        hit_trim;
  logic [15:0] ctrl_view;
  logic        new_ready;
  logic        sw_start;
  logic [5:0]  div_last;
  logic        sysclk_divider_tick;
  logic        rcout_tick;
  logic        rcout_clk;

  assign wr_access = ce_in && psel_in && penable_in && pwrite_in;
  assign rd_access = ce_in && psel_in && !penable_in && !pwrite_in;
  assign hit_ctrl  = (paddr_in == OSCSEL_CTRL_ADDR);
  assign hit_trim  = (paddr_in == OSCSEL_TRIM_ADDR);

  // Lock reads back only while the PLL is the running source.
  assign ctrl_view = {1'b0, current_source_sel, 1'b0, new_source_sel,
                      sysclk_divider,
                      lock_flag
                      && (current_source_sel == OSCSEL_SRC_PLL),
                      1'b0, clock_fail_flag, 1'b0, secondary_osc_enable,
                      switch_request};

  always_comb begin
    case (new_source_sel)
      OSCSEL_SRC_SEC:  new_ready = src_ready_in[0];
      OSCSEL_SRC_FAST: new_ready = src_ready_in[1];
      OSCSEL_SRC_SLOW: new_ready = src_ready_in[2];
      OSCSEL_SRC_PRI:  new_ready = src_ready_in[3];
      OSCSEL_SRC_PLL:  new_ready = src_ready_in[4] && pll_locked_in;
      default:         new_ready = 1'b0;
    endcase
  end

  // Register access, unlock keys and switch sequencing.
  always_comb begin
    next_current_source_sel   = current_source_sel;
    next_new_source_sel       = new_source_sel;
    next_sysclk_divider       = sysclk_divider;
    next_lock_flag            = lock_flag;
    next_clock_fail_flag      = clock_fail_flag;
    next_secondary_osc_enable = secondary_osc_enable;
    next_switch_request       = switch_request;
    next_rc_trim_field        = rc_trim_field;
    next_key_lo               = key_lo;
    next_key_hi               = key_hi;
    next_state                = state;
    next_prdata               = prdata_out;
    sw_start                  = 1'b0;

    if (rd_access) begin
      if (hit_ctrl) begin
        next_prdata = {16'h0000, ctrl_view};
      end else if (hit_trim) begin
        next_prdata = {28'h0000000, rc_trim_field};
      end else begin
        next_prdata = 32'h00000000;
      end
    end

    // Any other bus write cancels a half-entered key sequence.
    if (wr_access) begin
      next_key_lo = 2'b00;
      next_key_hi = 2'b00;
    end
    if (wr_access && hit_ctrl && pstrb_in == 4'h1) begin
      if (key_lo == 2'b10) begin
        next_sysclk_divider = pwdata_in[OSCSEL_SYSCLK_DIVIDER_LSB +: 2];
        next_secondary_osc_enable = pwdata_in[OSCSEL_SOSC_BIT];
        if (!pwdata_in[OSCSEL_FAIL_BIT]) begin
          next_clock_fail_flag = 1'b0;
        end
        if (pwdata_in[OSCSEL_SWREQ_BIT]) begin
          next_switch_request = 1'b1;
        end
      end else if (key_lo == 2'b01 && pwdata_in[7:0] == OSCSEL_KEY_LO2) begin
        next_key_lo = 2'b10;
      end else if (pwdata_in[7:0] == OSCSEL_KEY_LO1) begin
        next_key_lo = 2'b01;
      end
    end else if (wr_access && hit_ctrl && pstrb_in == 4'h2) begin
      if (key_hi == 2'b10) begin
        next_new_source_sel = pwdata_in[OSCSEL_NEW_LSB +: 3];
      end else if (key_hi == 2'b01 && pwdata_in[15:8] == OSCSEL_KEY_HI2) begin
        next_key_hi = 2'b10;
      end else if (pwdata_in[15:8] == OSCSEL_KEY_HI1) begin
        next_key_hi = 2'b01;
      end
    end else if (wr_access && hit_trim && pstrb_in[0]) begin
      next_rc_trim_field = pwdata_in[3:0];
    end

    case (state)
      OSCSEL_ST_IDLE: begin
        if (switch_request) begin
          if (new_source_sel == current_source_sel) begin
            next_switch_request = 1'b0;
          end else begin
            sw_start = 1'b1;
            next_state = OSCSEL_ST_WAIT;
          end
        end
      end
      OSCSEL_ST_WAIT: begin
        if (new_ready) begin
          next_state = OSCSEL_ST_SYNC;
        end
      end
      OSCSEL_ST_SYNC: begin
        // Change over on a postscaler boundary so no short clock leaves.
        if (sysclk_divider_tick) begin
          next_current_source_sel = new_source_sel;
          next_switch_request = 1'b0;
          next_state = OSCSEL_ST_IDLE;
        end
      end
      default: next_state = OSCSEL_ST_IDLE;
    endcase

    if (sw_start) begin
      next_lock_flag = 1'b0;
      next_clock_fail_flag = 1'b0;
    end else if (!pll_locked_in) begin
      next_lock_flag = 1'b0;
    end else if (current_source_sel == OSCSEL_SRC_PLL
                 || state != OSCSEL_ST_IDLE) begin
      next_lock_flag = 1'b1;
    end

    // A detected failure outranks software and the sequencer.
    if (clock_fail_in) begin
      next_clock_fail_flag = 1'b1;
      next_current_source_sel = OSCSEL_SRC_FAST;
      next_switch_request = 1'b0;
      next_state = OSCSEL_ST_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      current_source_sel <= 3'h0;
      new_source_sel <= 3'h0;
      sysclk_divider <= OSCSEL_SYSCLK_DIVIDER_RST;
      lock_flag <= 1'b0;
      clock_fail_flag <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request <= 1'b0;
      rc_trim_field <= OSCSEL_TRIM_RST;
      key_lo <= 2'b00;
      key_hi <= 2'b00;
      state <= OSCSEL_ST_IDLE;
      prdata_out <= 32'h00000000;
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      // Startup configuration is caught in the first cycle after release.
      current_source_sel <= startup_source_cfg_in;
      new_source_sel <= startup_source_cfg_in;
      cfg_loaded <= 1'b1;
    end else if (ce_in) begin
      current_source_sel <= next_current_source_sel;
      new_source_sel <= next_new_source_sel;
      sysclk_divider <= next_sysclk_divider;
      lock_flag <= next_lock_flag;
      clock_fail_flag <= next_clock_fail_flag;
      secondary_osc_enable <= next_secondary_osc_enable;
      switch_request <= next_switch_request;
      rc_trim_field <= next_rc_trim_field;
      key_lo <= next_key_lo;
      key_hi <= next_key_hi;
      state <= next_state;
      prdata_out <= next_prdata;
    end
  end

  always_comb begin
    case (sysclk_divider)
      2'h3:    div_last = 6'h3f;
      2'h2:    div_last = 6'h0f;
      2'h1:    div_last = 6'h03;
      default: div_last = 6'h00;
    endcase
  end

  oscsel_divider #(.WIDTH(6)) u_sysclk_divider (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .last_in  (div_last),
    .tick_out (sysclk_divider_tick)
  );

  // Half-period of the divide-by-four output is two cycles.
  oscsel_divider #(.WIDTH(2)) u_rcout (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .last_in  (2'(OSCSEL_RCO_DIV / 2 - 1)),
    .tick_out (rcout_tick)
  );

  // Primary mode decode: predivider, multiplier, PLL input, pin use.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_prediv_out <= 2'h1;
      pll_mult_out <= 5'h01;
      pll_input_sel_out <= 2'h0;
      primary_osc_out_oe_out <= 1'b0;
      primary_osc_out_out <= 1'b0;
      rcout_clk <= 1'b0;
      current_source_sel_out <= 3'h0;
      secondary_osc_enable_out <= 1'b0;
      rc_trim_field_out <= OSCSEL_TRIM_RST;
      sysclk_tick_out <= 1'b0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      case (primary_mode_cfg_in)
        OSCSEL_PM_XT4, OSCSEL_PM_HS2_4, OSCSEL_PM_HS3_4,
        OSCSEL_PM_EC4, OSCSEL_PM_FRC4:    pll_mult_out <= 5'h04;
        OSCSEL_PM_XT8, OSCSEL_PM_HS2_8, OSCSEL_PM_HS3_8,
        OSCSEL_PM_EC8, OSCSEL_PM_FRC8:    pll_mult_out <= 5'h08;
        OSCSEL_PM_XT16, OSCSEL_PM_HS2_16, OSCSEL_PM_HS3_16,
        OSCSEL_PM_EC16, OSCSEL_PM_FRC16:  pll_mult_out <= 5'h10;
        default:                          pll_mult_out <= 5'h01;
      endcase
      case (primary_mode_cfg_in)
        OSCSEL_PM_HS2_4, OSCSEL_PM_HS2_8,
        OSCSEL_PM_HS2_16: pll_prediv_out <= 2'h2;
        OSCSEL_PM_HS3_4, OSCSEL_PM_HS3_8,
        OSCSEL_PM_HS3_16: pll_prediv_out <= 2'h3;
        default:          pll_prediv_out <= 2'h1;
      endcase
      case (primary_mode_cfg_in)
        OSCSEL_PM_EC4, OSCSEL_PM_EC8, OSCSEL_PM_EC16:
          pll_input_sel_out <= 2'h1;
        OSCSEL_PM_FRC4, OSCSEL_PM_FRC8, OSCSEL_PM_FRC16:
          pll_input_sel_out <= 2'h2;
        default:
          pll_input_sel_out <= 2'h0;
      endcase
      if (rcout_tick) begin
        rcout_clk <= !rcout_clk;
      end
      primary_osc_out_oe_out <=
        (primary_mode_cfg_in == OSCSEL_PM_EXT_RC);
      primary_osc_out_out <=
        (primary_mode_cfg_in == OSCSEL_PM_EXT_RC) && rcout_clk;
      current_source_sel_out <= current_source_sel;
      secondary_osc_enable_out <= secondary_osc_enable;
      rc_trim_field_out <= rc_trim_field;
      sysclk_tick_out <= sysclk_divider_tick;
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !(hit_ctrl || hit_trim);
    end
  end

  swreq_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && cfg_loaded && state == OSCSEL_ST_SYNC && sysclk_divider_tick
    && !clock_fail_in
    |=> !switch_request && current_source_sel == $past(new_source_sel))
    else $error("switch did not complete");

  fail_to_fast_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && cfg_loaded && clock_fail_in
    |=> current_source_sel == OSCSEL_SRC_FAST && clock_fail_flag)
    else $error("fail did not force fast RC");

  lock_view_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_access && hit_ctrl && current_source_sel != OSCSEL_SRC_PLL
    |=> !prdata_out[OSCSEL_LOCK_BIT])
    else $error("lock visible without PLL");

  lock_loss_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && cfg_loaded && !pll_locked_in |=> !lock_flag)
    else $error("lock held after loss");

  redundant_clr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && cfg_loaded && state == OSCSEL_ST_IDLE && switch_request
    && new_source_sel == current_source_sel |=> !switch_request)
    else $error("redundant request not cleared");

  unimpl_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_access && hit_ctrl
    |=> prdata_out[31:15] == 17'h00000 && prdata_out[11] == 1'b0
    && prdata_out[4] == 1'b0 && prdata_out[2] == 1'b0)
    else $error("unimplemented bit set");

  rc_pin_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && primary_mode_cfg_in != OSCSEL_PM_EXT_RC
    |=> !primary_osc_out_oe_out)
    else $error("pin driven outside RC mode");

  crystal_prediv_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && primary_mode_cfg_in == OSCSEL_PM_HS3_16
    |=> pll_prediv_out == 2'h3 && pll_mult_out == 5'h10)
    else $error("wrong predivider");

  trim_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_access && hit_trim |=> prdata_out[31:4] == 28'h0000000)
    else $error("trim upper bits nonzero");
endmodule
`default_nettype wire

// ### rtl/oscsel_pkg.sv
/*
  Constants, register map and mode encodings of the oscillator clock select
  block. Assumes an APB slave with 32-bit data, one register per word.
*/
package oscsel_pkg;
  localparam logic [11:0] OSCSEL_CTRL_ADDR = 12'h000;
  localparam logic [11:0] OSCSEL_TRIM_ADDR = 12'h004;
  localparam logic [7:0]  OSCSEL_KEY_LO1   = 8'h46;
  localparam logic [7:0]  OSCSEL_KEY_LO2   = 8'h57;
  localparam logic [7:0]  OSCSEL_KEY_HI1   = 8'h78;
  localparam logic [7:0]  OSCSEL_KEY_HI2   = 8'h9a;
  localparam int          OSCSEL_CUR_LSB   = 12;
  localparam int          OSCSEL_NEW_LSB   = 8;
  localparam int          OSCSEL_SYSCLK_DIVIDER_LSB  = 6;
  localparam int          OSCSEL_LOCK_BIT  = 5;
  localparam int          OSCSEL_FAIL_BIT  = 3;
  localparam int          OSCSEL_SOSC_BIT  = 1;
  localparam int          OSCSEL_SWREQ_BIT = 0;
  localparam logic [3:0]  OSCSEL_TRIM_RST  = 4'h0;
  localparam logic [1:0]  OSCSEL_SYSCLK_DIVIDER_RST  = 2'h0;
  localparam int          OSCSEL_RCO_DIV   = 4;

  typedef enum logic [2:0] {
    OSCSEL_SRC_SEC  = 3'h0,
    OSCSEL_SRC_FAST = 3'h1,
    OSCSEL_SRC_SLOW = 3'h2,
    OSCSEL_SRC_PRI  = 3'h3,
    OSCSEL_SRC_PLL  = 3'h7
  } oscsel_src_t;

  typedef enum logic [1:0] {
    OSCSEL_ST_IDLE = 2'b00,
    OSCSEL_ST_WAIT = 2'b01,
    OSCSEL_ST_SYNC = 2'b11
  } oscsel_state_t;

  // Primary mode configuration codes, one per operating mode.
  typedef enum logic [4:0] {
    OSCSEL_PM_LO_XTAL    = 5'h00,
    OSCSEL_PM_MED_XTAL   = 5'h01,
    OSCSEL_PM_XT4        = 5'h02,
    OSCSEL_PM_XT8        = 5'h03,
    OSCSEL_PM_XT16       = 5'h04,
    OSCSEL_PM_HI_XTAL    = 5'h05,
    OSCSEL_PM_HS2_4      = 5'h06,
    OSCSEL_PM_HS2_8      = 5'h07,
    OSCSEL_PM_HS2_16     = 5'h08,
    OSCSEL_PM_HS3_4      = 5'h09,
    OSCSEL_PM_HS3_8      = 5'h0a,
    OSCSEL_PM_HS3_16     = 5'h0b,
    OSCSEL_PM_EXT_CLK    = 5'h0c,
    OSCSEL_PM_EXT_CLK_IO = 5'h0d,
    OSCSEL_PM_EC4        = 5'h0e,
    OSCSEL_PM_EC8        = 5'h0f,
    OSCSEL_PM_EC16       = 5'h10,
    OSCSEL_PM_EXT_RC     = 5'h11,
    OSCSEL_PM_EXT_RC_IO  = 5'h12,
    OSCSEL_PM_FRC4       = 5'h13,
    OSCSEL_PM_FRC8       = 5'h14,
    OSCSEL_PM_FRC16      = 5'h15
  } oscsel_pmode_t;
endpackage

// ### rtl/oscsel_divider.sv
/*
  Free-running divide-by-N tick generator used for the postscaler and the
  external RC clock output. Assumes one clock and an active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module oscsel_divider #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] last_in,
  output logic                  tick_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_tick;

  always_comb begin
    next_tick = (count >= last_in);
    next_count = next_tick ? '0 : count + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
/*
  Self-checking testbench of the oscillator clock select block.
  It drives the APB port and the oscillator status inputs by itself.
  The clock runs at 40 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import oscsel_pkg::*;
  logic          clk_in;
  logic          rst_n_in;
  logic          psel_in;
  logic          penable_in;
  logic          pwrite_in;
  logic [11:0]   paddr_in;
  logic [31:0]   pwdata_in;
  logic [3:0]    pstrb_in;
  logic [2:0]    startup_source_cfg_in;
  oscsel_pmode_t primary_mode_cfg_in;
  logic [4:0]    src_ready_in;
  logic          pll_locked_in;
  logic          clock_fail_in;
  wire  [31:0]   prdata_out;
  wire           pready_out;
  wire           pslverr_out;
  wire  [2:0]    current_source_sel_out;
  wire           secondary_osc_enable_out;
  wire  [3:0]    rc_trim_field_out;
  wire           sysclk_tick_out;
  wire  [1:0]    pll_prediv_out;
  wire  [4:0]    pll_mult_out;
  wire  [1:0]    pll_input_sel_out;
  wire           primary_osc_out_out;
  wire           primary_osc_out_oe_out;
  int            errors;
  int            n_compared;
  logic [31:0]   rd;
  logic          err_seen;
  logic          prev;
  oscsel_pmode_t md [5] = '{OSCSEL_PM_XT4, OSCSEL_PM_HS2_8, OSCSEL_PM_HS3_16,
                            OSCSEL_PM_EC16, OSCSEL_PM_FRC4};
  logic [4:0]    mu [5] = '{5'h04, 5'h08, 5'h10, 5'h10, 5'h04};
  logic [1:0]    pd [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [1:0]    sl [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};

  oscsel_top u_oscsel_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .startup_source_cfg_in(startup_source_cfg_in),
    .primary_mode_cfg_in(primary_mode_cfg_in),
    .src_ready_in(src_ready_in), .pll_locked_in(pll_locked_in),
    .clock_fail_in(clock_fail_in),
    .current_source_sel_out(current_source_sel_out),
    .secondary_osc_enable_out(secondary_osc_enable_out),
    .rc_trim_field_out(rc_trim_field_out),
    .sysclk_tick_out(sysclk_tick_out), .pll_prediv_out(pll_prediv_out),
    .pll_mult_out(pll_mult_out), .pll_input_sel_out(pll_input_sel_out),
    .primary_osc_out_out(primary_osc_out_out),
    .primary_osc_out_oe_out(primary_osc_out_oe_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    pstrb_in   <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("ERROR pready expected 1 seen 0");
    end
    rd       = prdata_out;
    err_seen = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd_ctrl();
    apb(1'b0, OSCSEL_CTRL_ADDR, 32'h0, 4'h0);
  endtask

  task automatic wr_lo(input logic [7:0] v);
    apb(1'b1, OSCSEL_CTRL_ADDR, {24'h0, OSCSEL_KEY_LO1}, 4'h1);
    apb(1'b1, OSCSEL_CTRL_ADDR, {24'h0, OSCSEL_KEY_LO2}, 4'h1);
    apb(1'b1, OSCSEL_CTRL_ADDR, {24'h0, v}, 4'h1);
  endtask

  task automatic wr_hi(input logic [7:0] v);
    apb(1'b1, OSCSEL_CTRL_ADDR, {16'h0, OSCSEL_KEY_HI1, 8'h0}, 4'h2);
    apb(1'b1, OSCSEL_CTRL_ADDR, {16'h0, OSCSEL_KEY_HI2, 8'h0}, 4'h2);
    apb(1'b1, OSCSEL_CTRL_ADDR, {16'h0, v, 8'h0}, 4'h2);
  endtask

  // Reads the control register until no switch is pending.
  task automatic poll_switch();
    int k;
    k = 0;
    do begin
      rd_ctrl();
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    if (rd[0] !== 1'b0) begin
      errors++;
      $display("ERROR switch expected 0 seen 1");
    end
  endtask

  task automatic wait_src(input logic [2:0] v);
    int k;
    k = 0;
    while (current_source_sel_out !== v && k < 200) begin
      @(posedge clk_in);
      k++;
    end
    if (current_source_sel_out !== v) begin
      errors++;
      $display("ERROR source expected %h seen %h", v, current_source_sel_out);
    end
  endtask

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #1ms;
    errors++;
    test_done();
  end

  initial begin
    int n;
    errors = 0;
    n_compared = 0;
    rst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    pstrb_in = 4'h0;
    startup_source_cfg_in = 3'h3;
    primary_mode_cfg_in = OSCSEL_PM_MED_XTAL;
    src_ready_in = 5'h00;
    pll_locked_in = 1'b0;
    clock_fail_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd_ctrl();
    check("ctrl reset", rd, 32'h3300);
    apb(1'b0, OSCSEL_TRIM_ADDR, 32'h0, 4'h0);
    check("trim reset", rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    check("unmapped err", {31'h0, err_seen}, 32'h1);
    apb(1'b1, OSCSEL_TRIM_ADDR, 32'hffff_fff8, 4'hf);
    apb(1'b0, OSCSEL_TRIM_ADDR, 32'h0, 4'h0);
    check("trim read", rd, 32'h8);
    check("trim out", {28'h0, rc_trim_field_out}, 32'h8);
    apb(1'b1, OSCSEL_CTRL_ADDR, 32'h42, 4'h1);
    rd_ctrl();
    check("locked write", rd, 32'h3300);
    wr_lo(8'h56);
    rd_ctrl();
    check("ctrl low", rd, 32'h3342);
    check("sec enable", {31'h0, secondary_osc_enable_out}, 32'h1);
    wr_hi(8'hff);
    rd_ctrl();
    check("ctrl high", rd, 32'h3742);
    wr_lo(8'h43);
    rd_ctrl();
    check("pending", rd & 32'h7001, 32'h3001);
    src_ready_in  <= 5'h1f;
    pll_locked_in <= 1'b1;
    poll_switch();
    wait_src(3'h7);
    rd_ctrl();
    check("pll switch", rd, 32'h7762);
    check("src out", {29'h0, current_source_sel_out}, 32'h7);
    pll_locked_in <= 1'b0;
    rd_ctrl();
    rd_ctrl();
    check("lock lost", {31'h0, rd[5]}, 32'h0);
    pll_locked_in <= 1'b1;
    @(posedge clk_in);
    clock_fail_in <= 1'b1;
    @(posedge clk_in);
    clock_fail_in <= 1'b0;
    wait_src(3'h1);
    rd_ctrl();
    check("fail", rd, 32'h174a);
    wr_lo(8'h42);
    rd_ctrl();
    check("fail clear", rd, 32'h1742);
    wr_hi(8'h01);
    wr_lo(8'h43);
    poll_switch();
    check("redundant", rd, 32'h1142);
    for (int i = 0; i < 5; i++) begin
      primary_mode_cfg_in <= md[i];
      repeat (3) @(posedge clk_in);
      check("mult", {27'h0, pll_mult_out}, {27'h0, mu[i]});
      check("prediv", {30'h0, pll_prediv_out}, {30'h0, pd[i]});
      check("pll in", {30'h0, pll_input_sel_out}, {30'h0, sl[i]});
    end
    primary_mode_cfg_in <= OSCSEL_PM_EXT_RC;
    repeat (4) @(posedge clk_in);
    check("rc out oe", {31'h0, primary_osc_out_oe_out}, 32'h1);
    n = 0;
    prev = primary_osc_out_out;
    repeat (16) begin
      @(posedge clk_in);
      if (primary_osc_out_out !== prev) n++;
      prev = primary_osc_out_out;
    end
    check("rc out toggles", n, 32'd8);
    primary_mode_cfg_in <= OSCSEL_PM_EXT_RC_IO;
    repeat (3) @(posedge clk_in);
    check("rc io oe", {31'h0, primary_osc_out_oe_out}, 32'h0);
    primary_mode_cfg_in <= OSCSEL_PM_EXT_CLK_IO;
    repeat (3) @(posedge clk_in);
    check("clk io oe", {31'h0, primary_osc_out_oe_out}, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr_lo({p[1:0], 6'h02});
      repeat (4) @(posedge clk_in);
      n = 0;
      repeat (128) begin
        @(posedge clk_in);
        if (sysclk_tick_out === 1'b1) n++;
      end
      check("ticks", n, 32'd128 >> (2 * p));
    end
    // A second reset in mid-run reloads both source fields.
    startup_source_cfg_in <= 3'h1;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd_ctrl();
    check("ctrl reset again", rd, 32'h1100);
    check("sec reset", {31'h0, secondary_osc_enable_out}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
